// *** wdt_pkg.sv ***
// Constants, option layout and bus carrier for the windowed watchdog.
// Assumes a single 125 MHz system clock; the slow oscillator arrives as a pin.
package wdt_pkg;

  // ---------------------------------------------------------------------------
  // Register map and values
  // ---------------------------------------------------------------------------
  localparam int          ADDR_W             = 4;
  localparam logic [3:0]  SERVICE_OFFSET     = 4'h0;
  localparam logic [3:0]  RESET_CAUSE_OFFSET = 4'h1;
  localparam logic [7:0]  SERVICE_KEY        = 8'hac;
  localparam logic [7:0]  SERVICE_READ_ON    = 8'h9a;
  localparam logic [7:0]  SERVICE_READ_OFF   = 8'h1a;
  localparam int          WDT_FLAG_BIT       = 4;

  // ---------------------------------------------------------------------------
  // Counter and option fields
  // ---------------------------------------------------------------------------
  localparam int          COUNT_W            = 17;
  localparam logic [7:0]  OPTION_RESET       = 8'h00;
  localparam logic [1:0]  WINDOW_50          = 2'h1;
  localparam logic [1:0]  WINDOW_75          = 2'h2;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 17'h00000;

  // Option byte: bit 7 irq, bits 6:5 window, bit 4 enable, bits 3:1 period, bit 0 standby
  typedef struct packed {
    logic       interval_irq_option;
    logic [1:0] window_select;
    logic       count_enable_option;
    logic [2:0] overflow_select;
    logic       standby_run_option;
  } option_t;

  // Register bus request from the CPU side
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic              wr;
    logic              rd;
    logic              bit_op;
  } bus_req_t;

  // Service phase, Gray coded along load -> first -> windowed
  typedef enum logic [1:0] {
    PH_LOAD     = 2'b00,
    PH_FIRST    = 2'b01,
    PH_WINDOWED = 2'b11
  } phase_t;

  // Overflow period as a power of two of slow-clock cycles
  function automatic logic [4:0] overflow_shift(input logic [2:0] sel);
    logic [4:0] s;
    s = 5'h10;
    unique case (sel)
      3'h0: s = 5'h06;
      3'h1: s = 5'h07;
      3'h2: s = 5'h08;
      3'h3: s = 5'h09;
      3'h4: s = 5'h0b;
      3'h5: s = 5'h0d;
      3'h6: s = 5'h0e;
      3'h7: s = 5'h10;
    endcase
    return s;
  endfunction

endpackage

// *** windowed_watchdog_timer.sv ***
// Windowed watchdog: counts slow oscillator cycles and requests chip reset.
// Assumes the reset controller pulls rst_n_in low once reset_request_out rises,
// and a separate power-on reset clears the cause flag only.
`timescale 1ns/1ps
`default_nettype none

module windowed_watchdog_timer
  import wdt_pkg::*;
(
  input  wire logic     clock_in,
  input  wire logic     rst_n_in,
  input  wire logic     por_n_in,
  input  wire logic     clk_en_in,
  input  wire logic     slow_clk_in,
  input  wire logic [7:0] option_byte_in,
  input  wire logic     halt_in,
  input  wire logic     stop_in,
  input  wire logic     snooze_in,
  input  wire bus_req_t bus_req_in,
  output logic [7:0]    bus_rdata_out,
  output logic          reset_request_out,
  output logic          interval_irq_out,
  output logic          watchdog_reset_flag_out
);

  // ---------------------------------------------------------------------------
  // Slow clock synchroniser and edge detect
  // ---------------------------------------------------------------------------
  logic sync1_q;
  logic sync2_q;
  logic sync3_q;
  logic slow_rise;
  logic slow_fall;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end else if (clk_en_in) begin
      sync1_q <= slow_clk_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  assign slow_rise = sync2_q & ~sync3_q;
  assign slow_fall = ~sync2_q & sync3_q;

  // ---------------------------------------------------------------------------
  // Option capture and derived limits
  // ---------------------------------------------------------------------------
  option_t            option_q;
  option_t            option_d;
  phase_t             phase_q;
  phase_t             phase_d;
  logic [COUNT_W-1:0] period;
  logic [COUNT_W-1:0] close_limit;
  logic [COUNT_W-1:0] irq_point;
  logic               standby_mode;
  logic               halt_stop_q;
  logic               halt_stop_d;
  logic               wake_clear;
  logic               running;

  assign period    = COUNT_W'(17'h00001 << overflow_shift(option_q.overflow_select));
  assign irq_point = period - (period >> 2);

  always_comb begin
    close_limit = COUNT_RESET;
    if (option_q.standby_run_option) begin
      unique case (option_q.window_select)
        WINDOW_50: close_limit = period >> 1;
        WINDOW_75: close_limit = period >> 2;
        default:   close_limit = COUNT_RESET;
      endcase
    end
  end

  assign standby_mode = (halt_in | stop_in | snooze_in) & ~option_q.standby_run_option;
  assign halt_stop_d  = (halt_in | stop_in) & ~option_q.standby_run_option;
  assign wake_clear   = halt_stop_q & ~halt_stop_d;
  assign running      = (phase_q != PH_LOAD) & option_q.count_enable_option & ~standby_mode;

  // ---------------------------------------------------------------------------
  // Service decode and counter
  // ---------------------------------------------------------------------------
  logic               svc_wr;
  logic               key_ok;
  logic               in_closed;
  logic               abnormal;
  logic               accepted;
  logic [COUNT_W-1:0] count_q;
  logic [COUNT_W-1:0] count_d;
  logic               clear_pend_q;
  logic               clear_pend_d;
  logic               overflow;
  logic               irq_pend_q;
  logic               irq_pend_d;
  logic               irq_d;
  logic               req_d;

  assign svc_wr    = bus_req_in.wr & (bus_req_in.addr == SERVICE_OFFSET);
  assign key_ok    = (bus_req_in.wdata == SERVICE_KEY) & ~bus_req_in.bit_op;
  assign in_closed = (phase_q == PH_WINDOWED) & (count_q < close_limit);
  assign abnormal  = svc_wr & running & (~key_ok | in_closed);
  assign accepted  = svc_wr & running & key_ok & ~in_closed;
  // overflow unless a clear is pending or arriving
  assign overflow  = running & slow_rise & ~clear_pend_q & ~accepted & (count_q == period - 17'h1);

  always_comb begin
    phase_d      = phase_q;
    count_d      = count_q;
    clear_pend_d = clear_pend_q | accepted;
    option_d     = option_q;
    irq_pend_d   = irq_pend_q;
    irq_d        = 1'b0;
    unique case (phase_q)
      PH_LOAD: begin
        // sample option byte once after release
        option_d = option_t'(option_byte_in);
        phase_d  = PH_FIRST;
      end
      PH_FIRST: begin
        if (accepted) begin
          phase_d = PH_WINDOWED;
        end
      end
      PH_WINDOWED: begin
        phase_d = PH_WINDOWED;
      end
      default: begin
        phase_d = PH_LOAD;
      end
    endcase
    if (wake_clear) begin
      count_d = COUNT_RESET;
    end else if (running && slow_rise) begin
      // clear applied at next slow edge
      if (clear_pend_q) begin
        count_d      = COUNT_RESET;
        clear_pend_d = accepted;
      end else begin
        // keep counting past the irq point
        count_d = count_q + 17'h00001;
        if (option_q.interval_irq_option && (count_d == irq_point)) begin
          irq_pend_d = 1'b1;
        end
      end
    end
    if (irq_pend_q && slow_fall) begin
      irq_pend_d = 1'b0;
      irq_d      = 1'b1;
    end
  end

  assign req_d = reset_request_out | abnormal | overflow;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_q           <= PH_LOAD;
      option_q          <= option_t'(OPTION_RESET);
      count_q           <= COUNT_RESET;
      clear_pend_q      <= 1'b0;
      irq_pend_q        <= 1'b0;
      halt_stop_q       <= 1'b0;
      interval_irq_out  <= 1'b0;
      reset_request_out <= 1'b0;
    end else if (clk_en_in) begin
      phase_q           <= phase_d;
      option_q          <= option_d;
      count_q           <= count_d;
      clear_pend_q      <= clear_pend_d;
      irq_pend_q        <= irq_pend_d;
      halt_stop_q       <= halt_stop_d;
      interval_irq_out  <= irq_d;
      reset_request_out <= req_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Reset cause flag and read port
  // ---------------------------------------------------------------------------
  logic       cause_rd;
  logic       flag_d;
  logic [7:0] rdata_d;

  assign cause_rd = bus_req_in.rd & (bus_req_in.addr == RESET_CAUSE_OFFSET);
  // set wins over clear on read
  assign flag_d   = (watchdog_reset_flag_out & ~cause_rd) | abnormal | overflow;

  always_ff @(posedge clock_in or negedge por_n_in) begin
    if (!por_n_in) begin
      watchdog_reset_flag_out <= 1'b0;
    end else if (clk_en_in) begin
      watchdog_reset_flag_out <= flag_d;
    end
  end

  // service reads show the enable state
  always_comb begin
    rdata_d = 8'h00;
    if (bus_req_in.rd) begin
      if (bus_req_in.addr == SERVICE_OFFSET) begin
        rdata_d = option_q.count_enable_option ? SERVICE_READ_ON : SERVICE_READ_OFF;
      end else if (cause_rd) begin
        rdata_d[WDT_FLAG_BIT] = watchdog_reset_flag_out;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bus_rdata_out <= 8'h00;
    end else if (clk_en_in) begin
      bus_rdata_out <= rdata_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  property p_no_count_disabled;
    clk_en_in && !option_q.count_enable_option && phase_q != PH_LOAD |=> count_q == COUNT_RESET;
  endproperty
  a_no_count_disabled: assert property (p_no_count_disabled)
    else $error("counter moved while disabled");

  property p_bad_key;
    clk_en_in && running && svc_wr && bus_req_in.wdata != SERVICE_KEY |=> reset_request_out;
  endproperty
  a_bad_key: assert property (p_bad_key)
    else $error("wrong key did not request reset");

  property p_bit_access;
    clk_en_in && running && svc_wr && bus_req_in.bit_op |=> reset_request_out;
  endproperty
  a_bit_access: assert property (p_bit_access)
    else $error("bit access did not request reset");

  property p_closed_window;
    clk_en_in && running && svc_wr && phase_q == PH_WINDOWED && count_q < close_limit
      |=> reset_request_out;
  endproperty
  a_closed_window: assert property (p_closed_window)
    else $error("closed window write not caught");

  property p_first_ok;
    clk_en_in && running && svc_wr && key_ok && phase_q == PH_FIRST
      |=> !reset_request_out || $past(reset_request_out);
  endproperty
  a_first_ok: assert property (p_first_ok)
    else $error("first service wrongly rejected");

  property p_overflow;
    clk_en_in && running && slow_rise && !clear_pend_q && !accepted && count_q == period - 17'h1
      |=> reset_request_out;
  endproperty
  a_overflow: assert property (p_overflow)
    else $error("overflow did not request reset");

  property p_clear_applied;
    clk_en_in && running && slow_rise && clear_pend_q && !wake_clear
      |=> count_q == COUNT_RESET && (!reset_request_out || $past(reset_request_out | abnormal));
  endproperty
  a_clear_applied: assert property (p_clear_applied)
    else $error("pending clear not applied");

  property p_req_held;
    reset_request_out |=> reset_request_out;
  endproperty
  a_req_held: assert property (p_req_held)
    else $error("reset request dropped");

  property p_window_forced;
    !option_q.standby_run_option |-> close_limit == COUNT_RESET;
  endproperty
  a_window_forced: assert property (p_window_forced)
    else $error("window not fully open");

  property p_irq_off;
    !option_q.interval_irq_option && !irq_pend_q |=> !interval_irq_out;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interval irq while disabled");

  property p_read_value;
    clk_en_in && bus_req_in.rd && bus_req_in.addr == SERVICE_OFFSET
      |=> bus_rdata_out == (option_q.count_enable_option ? SERVICE_READ_ON : SERVICE_READ_OFF);
  endproperty
  a_read_value: assert property (p_read_value)
    else $error("service read value wrong");

  property p_cause_flag;
    $rose(reset_request_out) |-> watchdog_reset_flag_out;
  endproperty
  a_cause_flag: assert property (p_cause_flag)
    else $error("cause flag not set");

endmodule

`default_nettype wire

// *** wdt_partner.sv ***
// Far side model: free running slow oscillator pin and chip reset controller.
// Assumes clock_in is the system clock and tb_rst_n_in the bench's own reset.
`timescale 1ns/1ps
`default_nettype none

module wdt_partner (
  input  wire logic tb_rst_n_in,
  input  wire logic clock_in,
  input  wire logic reset_request_in,
  output logic      slow_clk_out,
  output logic      rst_n_out
);
  logic [1:0] hold_q;

  // ---------------------------------------------------------------------------
  // Oscillator and reset controller
  // ---------------------------------------------------------------------------
  // Oscillator runs free, phase unrelated to clock_in
  initial begin
    slow_clk_out = 1'b0;
    forever #33 slow_clk_out = ~slow_clk_out;
  end

  always_ff @(posedge clock_in or negedge tb_rst_n_in) begin
    if (!tb_rst_n_in) begin
      hold_q <= 2'h0;
    end else if (reset_request_in) begin
      hold_q <= 2'h2;
    end else if (hold_q != 2'h0) begin
      hold_q <= hold_q - 2'h1;
    end
  end
  assign rst_n_out = tb_rst_n_in & (hold_q == 2'h0);
endmodule

`default_nettype wire

// *** test_windowed_watchdog_timer.sv ***
// Self-checking bench for the windowed watchdog.
// Assumes wdt_pkg and wdt_partner are compiled first.
`timescale 1ns/1ps
`default_nettype none

module test_windowed_watchdog_timer;
  import wdt_pkg::*;
  logic        clock_in = 1'b0;
  logic        tb_rst_n, por_n, slow_clk, rst_n, halt, stop, snooze, clk_en;
  logic        req_out, irq, flag, req_seen;
  logic [7:0]  opt, rdata, d, key;
  logic [31:0] lfsr_q;
  bus_req_t    req;
  int          slow_n, req_at, irq_at, miscompares, n_tests;
  int          pt[8] = '{64, 128, 256, 512, 2048, 8192, 16384, 65536};
  logic [1:0]  wc[4] = '{2'h1, 2'h2, 2'h3, 2'h1};
  logic        sbc[4] = '{1'b1, 1'b1, 1'b1, 1'b0};
  logic        bad[4] = '{1'b1, 1'b0, 1'b0, 1'b0};

  // ---------------------------------------------------------------------------
  // Clock, design and far side
  // ---------------------------------------------------------------------------
  always #4 clock_in = ~clock_in;

  windowed_watchdog_timer i_windowed_watchdog_timer (
    .clock_in(clock_in), .rst_n_in(rst_n), .por_n_in(por_n), .clk_en_in(clk_en),
    .slow_clk_in(slow_clk), .option_byte_in(opt), .halt_in(halt), .stop_in(stop),
    .snooze_in(snooze), .bus_req_in(req), .bus_rdata_out(rdata),
    .reset_request_out(req_out), .interval_irq_out(irq), .watchdog_reset_flag_out(flag));

  wdt_partner i_wdt_partner (
    .tb_rst_n_in(tb_rst_n), .clock_in(clock_in), .reset_request_in(req_out),
    .slow_clk_out(slow_clk), .rst_n_out(rst_n));

  always @(posedge slow_clk) slow_n++;
  always @(posedge clock_in) begin
    if (req_out === 1'b1 && req_seen !== 1'b1) begin
      req_seen <= 1'b1;
      req_at <= slow_n;
    end
    if (irq === 1'b1) irq_at <= slow_n;
  end

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  function automatic logic [7:0] mk(input logic i, input logic [1:0] w, input logic e,
                                    input logic [2:0] s, input logic b);
    return {i, w, e, s, b};
  endfunction

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkr(input int n, input int lo, input int hi);
    n_tests++;
    if (n < lo || n > hi) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, n, lo);
    end
  endtask

  task automatic start(input logic [7:0] o);
    opt <= o;
    tb_rst_n <= 1'b0;
    repeat (3) @(posedge clock_in);
    tb_rst_n <= 1'b1;
    req_seen <= 1'b0;
    irq_at = -1;
    slow_n = 0;
    repeat (2) @(posedge clock_in);
  endtask

  task automatic slow(input int n);
    repeat (n) @(posedge slow_clk);
    @(posedge clock_in);
  endtask

  task automatic wait_req(input int max);
    for (int k = 0; k < max * 12 && req_seen !== 1'b1; k++) @(posedge clock_in);
    if (req_seen !== 1'b1) begin
      miscompares++;
      results();
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v, input logic b);
    @(posedge clock_in);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0, bit_op: b};
    @(posedge clock_in);
    req <= '0;
    repeat (3) @(posedge clock_in);
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clock_in);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1, bit_op: 1'b0};
    @(posedge clock_in);
    req <= '0;
    #1 v = rdata;
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial begin
    lfsr_q = 32'hd4e21c9d;
    miscompares = 0;
    n_tests = 0;
    {tb_rst_n, por_n, halt, stop, snooze, req_seen} = '0;
    req = '0;
    clk_en = 1'b1;
    opt = 8'h00;
    repeat (2) @(posedge clock_in);
    por_n <= 1'b1;
    start(mk(1'b0, 2'h3, 1'b1, 3'h0, 1'b1));
    rd(SERVICE_OFFSET, d);
    chk(d, SERVICE_READ_ON);
    rd(4'h5, d);
    chk(d, 8'h00);
    start(mk(1'b0, 2'h3, 1'b0, 3'h0, 1'b1));
    rd(SERVICE_OFFSET, d);
    chk(d, SERVICE_READ_OFF);
    slow(80);
    chk(req_seen, 1'b0);
    for (int s = 0; s < 5; s++) begin
      start(mk(1'b0, 2'h3, 1'b1, s[2:0], 1'b1));
      wait_req(pt[s] + 4);
      chkr(req_at, pt[s] - 1, pt[s] + 1);
      chk(irq_at, -1);
    end
    repeat (4) @(posedge clock_in);
    chk(flag, 1'b1);
    rd(RESET_CAUSE_OFFSET, d);
    chk(d[WDT_FLAG_BIT], 1'b1);
    rd(RESET_CAUSE_OFFSET, d);
    chk(d[WDT_FLAG_BIT], 1'b0);
    start(mk(1'b1, 2'h3, 1'b1, 3'h0, 1'b1));
    wait_req(70);
    chkr(irq_at, 47, 49);
    chkr(req_at, 63, 65);
    for (int i = 0; i < 4; i++) begin
      start(mk(1'b0, 2'h3, 1'b1, 3'h0, 1'b1));
      lfsr_q = nxt(lfsr_q);
      repeat (lfsr_q[11:8]) @(posedge clock_in);
      key = lfsr_q[7:0] ^ {7'h00, lfsr_q[7:0] == SERVICE_KEY};
      wr(SERVICE_OFFSET, (i == 3) ? SERVICE_KEY : key, i == 3);
      chk(req_seen, 1'b1);
    end
    for (int i = 0; i < 4; i++) begin
      start(mk(1'b0, wc[i], 1'b1, 3'h0, sbc[i]));
      slow(5);
      wr(SERVICE_OFFSET, SERVICE_KEY, 1'b0);
      chk(req_seen, 1'b0);
      slow(20);
      wr(SERVICE_OFFSET, SERVICE_KEY, 1'b0);
      chk(req_seen, bad[i]);
      if (!bad[i]) begin
        slow_n = 0;
        wait_req(70);
        chkr(req_at, 63, 66);
      end
    end
    start(mk(1'b0, 2'h3, 1'b1, 3'h0, 1'b1));
    slow(63);
    wr(SERVICE_OFFSET, SERVICE_KEY, 1'b0);
    slow(4);
    chk(req_seen, 1'b0);
    clk_en <= 1'b0;
    slow(100);
    chk(req_seen, 1'b0);
    clk_en <= 1'b1;
    slow_n = 0;
    wait_req(70);
    chkr(req_at, 57, 64);
    for (int m = 0; m < 3; m++) begin
      start(mk(1'b0, 2'h3, 1'b1, 3'h0, 1'b0));
      slow(40);
      halt <= (m == 0);
      stop <= (m == 1);
      snooze <= (m == 2);
      slow(100);
      chk(req_seen, 1'b0);
      {halt, stop, snooze} <= 3'h0;
      slow_n = 0;
      wait_req(70);
      chkr(req_at, (m < 2) ? 63 : 23, (m < 2) ? 65 : 25);
    end
    results();
  end
endmodule

`default_nettype wire
